// ---- design/eesq_top.sv ----
// Summary of operation
// - enable command keeps erase/write allowed until disable command.
// - write command stores data byte at the addressed location.
// - write-all command writes data byte into every location.
// - erase-all command starts a bulk erase of the whole array.
// - no ready within 30 ms: abandon, go idle, set sticky time-out.
// - address-loaded flag sets after a boot load or reload whose signature byte matches; write one clears.
// - location field is 8 bits, a byte address for the operation.
// - data byte holds last byte read or byte to be written.
`timescale 1ns/10ps
module eesq_top #(
  parameter int TIMEOUT_CYCLES = eesq_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host command and data
  input wire logic cmd_valid,
  input wire eesq_pkg::eesq_cmd_s cmd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic clr_timeout,
  input wire logic clr_addr_loaded,
  // host status
  output eesq_pkg::eesq_stat_s status,
  output logic [7:0] data_rdata,
  output logic [47:0] station_addr,
  // eeprom pins
  output eesq_pkg::eesq_pins_s pins,
  input wire logic eeprom_serial_io_in
);
  import eesq_pkg::*;

  localparam logic [CNT_W-1:0] TMO_M1 = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] GAP_M1 = CNT_W'(GAP_CYC - 1);
  localparam logic [7:0] STATION_SIG = 8'ha5;

  eesq_top_s s_reg;
  eesq_top_s s_next;
  logic sh_done;
  logic [7:0] sh_rx;
  logic sh_sk;
  logic sh_dout;
  logic sh_oe;

  function automatic eesq_frame_s frame_of(eesq_cmd_e op,
    logic [7:0] a, logic [7:0] d);
    eesq_frame_s f;
    f.len = HDR_LEN;
    f.rx = 1'b0;
    f.bits = {1'b1, WOP_MISC, a, d};
    unique case (op)
      CMD_READ, CMD_RELOAD:
      begin
        f.bits = {1'b1, WOP_READ, a, 8'h00};
        f.rx = 1'b1;
      end
      ERASE_WRITE_DISABLE_CMD:
        f.bits = {1'b1, WOP_MISC, PFX_DISABLE, 6'h00, 8'h00};
      ERASE_WRITE_ENABLE_CMD:
        f.bits = {1'b1, WOP_MISC, PFX_ENABLE, 6'h00, 8'h00};
      CMD_WRITE:
      begin
        f.bits = {1'b1, WOP_WRITE, a, d};
        f.len = FULL_LEN;
      end
      WRITE_ALL_CMD:
      begin
        f.bits = {1'b1, WOP_MISC, PFX_WRITE_ALL, 6'h00, d};
        f.len = FULL_LEN;
      end
      CMD_ERASE: f.bits = {1'b1, WOP_ERASE, a, 8'h00};
      ERASE_ALL_CMD:
        f.bits = {1'b1, WOP_MISC, PFX_ERASE_ALL, 6'h00, 8'h00};
    endcase
    return f;
  endfunction

  function automatic eesq_top_s launch(eesq_top_s t, eesq_cmd_e op,
    logic [7:0] a);
    t.op = op;
    t.addr = a;
    t.frame = frame_of(op, a, t.eeprom_byte_register);
    t.sh_start = 1'b1;
    t.pins.cs = 1'b1;
    t.st = ST_SHIFT;
    t.stat.busy = 1'b1;
    return t;
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.sh_start = 1'b0;
    s_next.pins.sk = sh_sk;
    s_next.pins.eeprom_serial_io_out = sh_dout;
    s_next.pins.eeprom_serial_io_oe = sh_oe;
    // clears first so a same-cycle set wins
    if (clr_timeout)
      s_next.stat.timeout = 1'b0;
    if (clr_addr_loaded)
      s_next.stat.addr_loaded = 1'b0;
    unique case (s_reg.st)
      ST_IDLE:
        if (s_reg.boot)
        begin
          s_next.boot = 1'b0;
          s_next.reload = 1'b1;
          s_next.ridx = 3'h0;
          s_next = launch(s_next, CMD_RELOAD, 8'h00);
        end
        else if (cmd_valid)
        begin
          s_next.reload = (cmd.op == CMD_RELOAD);
          s_next.ridx = 3'h0;
          s_next = launch(s_next, cmd.op, (cmd.op == CMD_RELOAD) ?
            8'h00 : cmd.eeprom_location_field);
        end
        else if (data_wr)
          s_next.eeprom_byte_register = data_wdata;
      ST_SHIFT:
        if (sh_done)
        begin
          s_next.pins.cs = 1'b0;
          s_next.cnt = '0;
          s_next.st = ST_GAP;
          s_next.poll = (s_reg.op == CMD_WRITE) ||
            (s_reg.op == WRITE_ALL_CMD) || (s_reg.op == CMD_ERASE) ||
            (s_reg.op == ERASE_ALL_CMD);
          if (s_reg.op == ERASE_WRITE_ENABLE_CMD)
            s_next.stat.wr_enabled = 1'b1;
          if (s_reg.op == ERASE_WRITE_DISABLE_CMD)
            s_next.stat.wr_enabled = 1'b0;
          if (s_reg.op == CMD_READ)
            s_next.eeprom_byte_register = sh_rx;
          if (s_reg.op == CMD_RELOAD)
          begin
            s_next.ridx = s_reg.ridx + 3'h1;
            if (s_reg.ridx == 3'h0)
            begin
              if (sh_rx != STATION_SIG)
                s_next.reload = 1'b0;
            end
            else
              s_next.station[{s_reg.ridx - 3'h1, 3'h0} +: 8] = sh_rx;
            if (s_reg.ridx == 3'(STATION_BYTES))
            begin
              s_next.reload = 1'b0;
              s_next.stat.addr_loaded = 1'b1;
            end
          end
        end
      ST_GAP:
        if (s_reg.cnt == GAP_M1)
        begin
          if (s_reg.poll)
          begin
            s_next.st = ST_POLL;
            s_next.pins.cs = 1'b1;
            s_next.cnt = '0;
          end
          else if (s_reg.reload)
            s_next = launch(s_next, CMD_RELOAD, {5'h00, s_reg.ridx});
          else
          begin
            s_next.st = ST_IDLE;
            s_next.stat.busy = 1'b0;
          end
        end
        else
          s_next.cnt = s_reg.cnt + CNT_W'(1);
      ST_POLL:
        if (eeprom_serial_io_in)
        begin
          s_next.pins.cs = 1'b0;
          s_next.poll = 1'b0;
          s_next.cnt = '0;
          s_next.st = ST_GAP;
        end
        else if (s_reg.cnt == TMO_M1)
        begin
          s_next.stat.timeout = 1'b1;
          s_next.pins.cs = 1'b0;
          s_next.poll = 1'b0;
          s_next.st = ST_IDLE;
          s_next.stat.busy = 1'b0;
        end
        else
          s_next.cnt = s_reg.cnt + CNT_W'(1);
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= TOP_RST;
    else
      s_reg <= s_next;
  end

  eesq_shift u_shift (
    .clk(clk),
    .resetn(resetn),
    .start(s_reg.sh_start),
    .frame(s_reg.frame),
    .done(sh_done),
    .rx(sh_rx),
    .din(eeprom_serial_io_in),
    .sk(sh_sk),
    .dout(sh_dout),
    .oe(sh_oe)
  );

  assign status = s_reg.stat;
  assign data_rdata = s_reg.eeprom_byte_register;
  assign station_addr = s_reg.station;
  assign pins = s_reg.pins;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ENABLE_SET: assert property ($rose(s_reg.stat.wr_enabled) |->
    $past(s_reg.op) == ERASE_WRITE_ENABLE_CMD && $past(sh_done))
    else $error("write enable set without enable command");
  AST_ENABLE_KEEP: assert property ($fell(s_reg.stat.wr_enabled) |->
    $past(s_reg.op) == ERASE_WRITE_DISABLE_CMD && $past(sh_done))
    else $error("write enable lost without disable command");
  AST_WRITE_FRAME: assert property (s_reg.sh_start &&
    s_reg.op == CMD_WRITE |-> s_reg.frame.len == FULL_LEN &&
    s_reg.frame.bits == {1'b1, WOP_WRITE, s_reg.addr, data_rdata})
    else $error("write frame wrong");
  AST_WRITE_ALL_FRAME: assert property (s_reg.sh_start &&
    s_reg.op == WRITE_ALL_CMD |-> s_reg.frame.len == FULL_LEN &&
    s_reg.frame.bits == {1'b1, WOP_MISC, PFX_WRITE_ALL, 6'h00, data_rdata})
    else $error("write-all frame wrong");
  AST_ERASE_ALL_FRAME: assert property (s_reg.sh_start &&
    s_reg.op == ERASE_ALL_CMD |-> s_reg.frame.len == HDR_LEN &&
    s_reg.frame.bits[18:8] == {1'b1, WOP_MISC, PFX_ERASE_ALL, 6'h00})
    else $error("erase-all frame wrong");
  AST_ERASE_FRAME: assert property (s_reg.sh_start &&
    s_reg.op == CMD_ERASE |-> s_reg.frame.len == HDR_LEN &&
    s_reg.frame.bits[18:8] == {1'b1, WOP_ERASE, s_reg.addr})
    else $error("erase frame wrong");
  AST_TMO_SET: assert property ($rose(s_reg.stat.timeout) |->
    $past(s_reg.st) == ST_POLL && $past(s_reg.cnt) == TMO_M1 &&
    s_reg.st == ST_IDLE && !status.busy && !pins.cs)
    else $error("time-out at wrong moment");
  AST_TMO_BOUND: assert property (s_reg.st == ST_POLL |->
    s_reg.cnt <= TMO_M1)
    else $error("poll ran past time-out");
  AST_LOADED: assert property ($rose(s_reg.stat.addr_loaded) |->
    $past(s_reg.reload) && $past(s_reg.ridx) == 3'(STATION_BYTES))
    else $error("address-loaded set early");
  AST_ADDR_TAKE: assert property (s_reg.st == ST_IDLE && !s_reg.boot &&
    cmd_valid && cmd.op != CMD_RELOAD |=> s_reg.st == ST_SHIFT &&
    s_reg.addr == $past(cmd.eeprom_location_field))
    else $error("location not taken");
  AST_READ_DATA: assert property (s_reg.st == ST_SHIFT && sh_done &&
    s_reg.op == CMD_READ |=> data_rdata == $past(sh_rx) && !pins.cs)
    else $error("read byte not stored");

  COV_TIMEOUT: cover property ($rose(s_reg.stat.timeout));
  COV_LOADED: cover property ($rose(s_reg.stat.addr_loaded));
  COV_WRITE_DONE: cover property (s_reg.st == ST_POLL &&
    s_reg.op == CMD_WRITE && eeprom_serial_io_in);
  COV_READ: cover property (s_reg.st == ST_SHIFT && sh_done &&
    s_reg.op == CMD_READ);
endmodule

// ---- design/eesq_pkg.sv ----
package eesq_pkg;
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int SK_FREQ_HZ = 1_000_000;
  localparam int SK_HALF_CYC =
    (CLK_FREQ_HZ + 2 * SK_FREQ_HZ - 1) / (2 * SK_FREQ_HZ);
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int GAP_CYC = SK_HALF_CYC;
  localparam int CNT_W = 21;
  localparam int FRAME_W = 19;
  localparam int STATION_BYTES = 6;
  localparam logic [4:0] SK_HALF_M1 = 5'(SK_HALF_CYC - 1);
  localparam logic [4:0] HDR_LEN = 5'h0b;
  localparam logic [4:0] FULL_LEN = 5'h13;
  localparam logic [4:0] RX_LEN = 5'h08;
  localparam logic [1:0] WOP_READ = 2'h2;
  localparam logic [1:0] WOP_WRITE = 2'h1;
  localparam logic [1:0] WOP_ERASE = 2'h3;
  localparam logic [1:0] WOP_MISC = 2'h0;
  localparam logic [1:0] PFX_ENABLE = 2'h3;
  localparam logic [1:0] PFX_DISABLE = 2'h0;
  localparam logic [1:0] PFX_ERASE_ALL = 2'h2;
  localparam logic [1:0] PFX_WRITE_ALL = 2'h1;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    ERASE_WRITE_DISABLE_CMD = 3'h1,
    ERASE_WRITE_ENABLE_CMD = 3'h2,
    CMD_WRITE = 3'h3,
    WRITE_ALL_CMD = 3'h4,
    CMD_ERASE = 3'h5,
    ERASE_ALL_CMD = 3'h6,
    CMD_RELOAD = 3'h7
  } eesq_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHIFT = 4'h2,
    ST_GAP = 4'h4,
    ST_POLL = 4'h8
  } eesq_state_e;

  typedef struct packed {
    eesq_cmd_e op;
    logic [7:0] eeprom_location_field;
  } eesq_cmd_s;

  typedef struct packed {
    logic cs;
    logic sk;
    logic eeprom_serial_io_out;
    logic eeprom_serial_io_oe;
  } eesq_pins_s;

  typedef struct packed {
    logic busy;
    logic timeout;
    logic addr_loaded;
    logic wr_enabled;
  } eesq_stat_s;

  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [4:0] len;
    logic rx;
  } eesq_frame_s;

  typedef struct packed {
    logic active;
    logic done;
    logic sk;
    logic dout;
    logic oe;
    logic rxf;
    logic [4:0] len;
    logic [4:0] bitn;
    logic [4:0] cnt;
    logic [FRAME_W-1:0] sh;
    logic [7:0] rx;
  } eesq_shift_s;

  typedef struct packed {
    eesq_state_e st;
    eesq_cmd_e op;
    logic [7:0] addr;
    logic [7:0] eeprom_byte_register;
    eesq_frame_s frame;
    logic sh_start;
    eesq_pins_s pins;
    eesq_stat_s stat;
    logic boot;
    logic reload;
    logic poll;
    logic [2:0] ridx;
    logic [47:0] station;
    logic [CNT_W-1:0] cnt;
  } eesq_top_s;

  localparam eesq_top_s TOP_RST = '{st: ST_IDLE, op: CMD_READ,
    addr: ADDR_RST, eeprom_byte_register: DATA_RST, boot: 1'b1,
    stat: '{busy: 1'b1, default: 1'b0}, default: '0};
endpackage

// ---- design/eesq_shift.sv ----
`timescale 1ns/10ps
module eesq_shift (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // frame request
  input wire logic start,
  input wire eesq_pkg::eesq_frame_s frame,
  output logic done,
  output logic [7:0] rx,
  // serial pins
  input wire logic din,
  output logic sk,
  output logic dout,
  output logic oe
);
  import eesq_pkg::*;

  eesq_shift_s s_reg;
  eesq_shift_s s_next;
  logic rx_ph;
  logic [4:0] last;

  assign rx_ph = s_reg.rxf && (s_reg.bitn >= s_reg.len);
  assign last = s_reg.len + (s_reg.rxf ? RX_LEN : 5'h00) - 5'h01;

  // msb first, data driven on low phase, sampled on rising sk
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.active)
    begin
      if (start)
      begin
        s_next.active = 1'b1;
        s_next.sh = frame.bits;
        s_next.len = frame.len;
        s_next.rxf = frame.rx;
        s_next.bitn = 5'h00;
        s_next.cnt = 5'h00;
        s_next.sk = 1'b0;
        s_next.oe = 1'b1;
        s_next.dout = frame.bits[FRAME_W-1];
      end
    end
    else if (s_reg.cnt != SK_HALF_M1)
      s_next.cnt = s_reg.cnt + 5'h01;
    else
    begin
      s_next.cnt = 5'h00;
      s_next.sk = !s_reg.sk;
      if (!s_reg.sk)
      begin
        if (rx_ph)
          s_next.rx = {s_reg.rx[6:0], din};
      end
      else if (s_reg.bitn == last)
      begin
        s_next.active = 1'b0;
        s_next.done = 1'b1;
        s_next.oe = 1'b0;
        s_next.dout = 1'b0;
      end
      else
      begin
        s_next.bitn = s_reg.bitn + 5'h01;
        s_next.sh = {s_reg.sh[FRAME_W-2:0], 1'b0};
        s_next.dout = s_reg.sh[FRAME_W-2];
        s_next.oe = !(s_reg.rxf && (s_next.bitn >= s_reg.len));
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign done = s_reg.done;
  assign rx = s_reg.rx;
  assign sk = s_reg.sk;
  assign dout = s_reg.dout;
  assign oe = s_reg.oe;
endmodule

// ---- tb/eesq_eeprom_model.sv ----
`timescale 1ns/10ps
module eesq_eeprom_model (
  // clock
  input wire logic clk,
  // controller pins and resolved wire
  input wire eesq_pkg::eesq_pins_s pins,
  output logic wire_lvl,
  // behaviour knobs
  input wire logic [15:0] busy_cyc,
  input wire logic dead
);
  import eesq_pkg::*;
  logic [7:0] mem [256];
  logic [18:0] sh;
  logic [10:0] hdr;
  logic en, sk_d, drv, dval, flip;
  int nb, busy;
  initial
  begin
    en = 1'b0;
    sk_d = 1'b0;
    drv = 1'b0;
    dval = 1'b0;
    flip = 1'b0;
    nb = 0;
    busy = 0;
    hdr = '0;
    sh = '0;
  end
  // ready status before a start bit; released wire toggles
  assign wire_lvl = pins.eeprom_serial_io_oe ? pins.eeprom_serial_io_out :
    !pins.cs ? flip : nb == 0 ? busy == 0 && !dead : drv ? dval : flip;
  always @(posedge clk)
  begin
    flip <= ~flip;
    sk_d <= pins.sk;
    if (busy > 0)
      busy <= busy - 1;
    if (!pins.cs)
    begin
      drv <= 1'b0;
      nb <= 0;
      if (nb >= 11 && !dead)
      begin
        if (hdr[9:8] == WOP_MISC && hdr[7:6] == PFX_ENABLE)
          en <= 1'b1;
        if (hdr[9:8] == WOP_MISC && hdr[7:6] == PFX_DISABLE)
          en <= 1'b0;
        if (en)
        begin
          busy <= busy_cyc;
          for (int i = 0; i < 256; i++)
          begin
            if (nb == 19 && (hdr[9:8] == WOP_WRITE && i == hdr[7:0] ||
              hdr[9:8] == WOP_MISC && hdr[7:6] == PFX_WRITE_ALL))
              mem[i] <= sh[7:0];
            if (hdr[9:8] == WOP_ERASE && i == hdr[7:0] ||
              hdr[9:8] == WOP_MISC && hdr[7:6] == PFX_ERASE_ALL)
              mem[i] <= 8'hff;
          end
        end
      end
    end
    else if (pins.sk && !sk_d)
    begin
      sh <= {sh[17:0], wire_lvl};
      nb <= nb + 1;
      if (nb == 10)
        hdr <= {sh[9:0], wire_lvl};
    end
    else if (!pins.sk && sk_d && nb >= 11 && nb < 19 &&
      hdr[9:8] == WOP_READ)
    begin
      drv <= 1'b1;
      dval <= mem[hdr[7:0]][18-nb];
    end
  end
endmodule

// ---- tb/tb_eesq_top.sv ----
`timescale 1ns/10ps
module tb_eesq_top;
  import eesq_pkg::*;
  localparam int TO_CYC = 200;
  localparam logic [7:0] SIG = 8'ha5;
  logic clk, resetn, cmd_valid, data_wr, clr_timeout, clr_addr_loaded;
  logic dead, io, ren, rto, rld;
  logic [15:0] busy_cyc;
  logic [7:0] data_wdata, data_rdata, rdat;
  logic [47:0] station_addr, rsta;
  logic [7:0] rmem [256];
  logic [31:0] seed;
  int n_mismatch, n_tests;
  eesq_cmd_s cmd;
  eesq_stat_s status;
  eesq_pins_s pins;

  eesq_top #(.TIMEOUT_CYCLES(TO_CYC)) i_eesq_top (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .data_wr(data_wr), .data_wdata(data_wdata), .clr_timeout(clr_timeout),
    .clr_addr_loaded(clr_addr_loaded), .status(status),
    .data_rdata(data_rdata), .station_addr(station_addr), .pins(pins),
    .eeprom_serial_io_in(io)
  );
  eesq_eeprom_model i_eesq_eeprom_model (
    .clk(clk), .pins(pins), .wire_lvl(io), .busy_cyc(busy_cyc),
    .dead(dead)
  );

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (status.busy !== 1'b0 && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 20000)
      check("idle wait", 1'b0, 1'b1);
  endtask

  task automatic reload();
    if (rmem[0] == SIG)
    begin
      rld = 1'b1;
      for (int i = 1; i <= 6; i++)
        rsta[8*i-8 +: 8] = rmem[i];
    end
  endtask

  task automatic compare(logic dchk);
    check("status", status, {1'b0, rto, rld, ren});
    check("station", station_addr, rsta);
    if (dchk)
      check("data", data_rdata, rdat);
    for (int i = 0; i < 256; i++)
      check("mem", i_eesq_eeprom_model.mem[i], rmem[i]);
  endtask

  task automatic run(eesq_cmd_e op, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    data_wr = 1'b1;
    data_wdata = d;
    rdat = d;
    @(negedge clk);
    data_wr = 1'b0;
    cmd_valid = 1'b1;
    cmd = '{op: op, eeprom_location_field: a};
    @(negedge clk);
    check("busy", status.busy, 1'b1);
    // held high while busy: must be ignored
    cmd = '{op: ERASE_ALL_CMD, eeprom_location_field: 8'h00};
    data_wr = 1'b1;
    data_wdata = ~d;
    @(negedge clk);
    cmd_valid = 1'b0;
    data_wr = 1'b0;
    wait_idle();
    case (op)
      ERASE_WRITE_ENABLE_CMD: ren = 1'b1;
      ERASE_WRITE_DISABLE_CMD: ren = 1'b0;
      CMD_READ: rdat = rmem[a];
      CMD_RELOAD: reload();
      default:
        if (dead)
          rto = 1'b1;
        else if (ren)
          for (int i = 0; i < 256; i++)
            if (op == WRITE_ALL_CMD || op == CMD_WRITE && i == a)
              rmem[i] = d;
            else if (op == ERASE_ALL_CMD || op == CMD_ERASE && i == a)
              rmem[i] = 8'hff;
    endcase
    compare(op != CMD_RELOAD);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #1_200_000;
    check("watchdog", 1'b0, 1'b1);
    end_of_test();
  end

  initial
  begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    data_wr = 1'b0;
    clr_timeout = 1'b0;
    clr_addr_loaded = 1'b0;
    cmd = '{op: CMD_READ, eeprom_location_field: 8'h00};
    data_wdata = 8'h00;
    busy_cyc = 16'h0014;
    dead = 1'b0;
    seed = 32'hfd98;
    n_mismatch = 0;
    n_tests = 0;
    {ren, rto, rld, rdat, rsta} = '0;
    for (int i = 0; i < 256; i++)
      rmem[i] = (i == 0) ? SIG : rnd();
    for (int i = 0; i < 256; i++)
      i_eesq_eeprom_model.mem[i] = rmem[i];
    repeat (20) @(negedge clk);
    check("reset busy", status.busy, 1'b1);
    resetn = 1'b1;
    wait_idle();
    reload();
    compare(1'b1);
    clr_addr_loaded = 1'b1;
    rld = 1'b0;
    @(negedge clk);
    clr_addr_loaded = 1'b0;
    run(CMD_WRITE, rnd(), rnd());
    run(ERASE_WRITE_ENABLE_CMD, 8'h00, 8'h00);
    run(CMD_WRITE, 8'hff, rnd());
    run(CMD_READ, 8'hff, 8'h00);
    run(CMD_WRITE, rnd(), rnd());
    run(CMD_ERASE, 8'hff, 8'h00);
    run(CMD_READ, 8'hff, 8'h00);
    busy_cyc = 16'h0096;
    run(WRITE_ALL_CMD, 8'h00, rnd());
    run(ERASE_ALL_CMD, 8'h00, 8'h00);
    run(CMD_RELOAD, 8'h00, 8'h00);
    run(CMD_WRITE, 8'h00, SIG);
    run(CMD_WRITE, 8'h04, rnd());
    run(CMD_RELOAD, 8'h00, 8'h00);
    dead = 1'b1;
    run(CMD_WRITE, 8'h05, rnd());
    run(WRITE_ALL_CMD, 8'h00, rnd());
    run(CMD_ERASE, 8'h05, 8'h00);
    run(ERASE_ALL_CMD, 8'h00, 8'h00);
    dead = 1'b0;
    run(CMD_READ, 8'h04, 8'h00);
    clr_timeout = 1'b1;
    rto = 1'b0;
    @(negedge clk);
    clr_timeout = 1'b0;
    run(ERASE_WRITE_DISABLE_CMD, 8'h00, 8'h00);
    run(CMD_WRITE, 8'h04, rnd());
    end_of_test();
  end
endmodule
